// [pkg/axis_comparator_bank_pkg.sv]
/*
 * Constants for the five-way axis comparator bank: register offsets, field positions,
 * condition, action and pin-function codes, and reset values.
 * Assumes a 32-bit classic Wishbone bus with byte addresses and one word per register.
 */
package axis_comparator_bank_pkg;

  // ********************************************************************
  // Widths.
  // ********************************************************************
  localparam int unsigned CMP_W = 28;
  localparam int unsigned NUM_CMP = 5;
  localparam int unsigned ADR_W = 8;

  // ********************************************************************
  // Register byte offsets.
  // ********************************************************************
  localparam logic [7:0] OFS_CONFIG_A = 8'h00;
  localparam logic [7:0] OFS_CONFIG_B = 8'h04;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFS_IRQ_CAUSE = 8'h0c;
  localparam logic [7:0] OFS_MAIN_STATUS = 8'h10;
  localparam logic [7:0] OFS_PIN_FUNCTION = 8'h14;
  localparam logic [7:0] OFS_COMPARE_BASE = 8'h18;
  localparam logic [7:0] OFS_COMPARE_LAST = 8'h28;

  // ********************************************************************
  // Field positions (low bit of each field).
  // ********************************************************************
  localparam int unsigned POS_C1_TARGET = 0;
  localparam int unsigned POS_C1_COND = 2;
  localparam int unsigned POS_C1_ACTION = 5;
  localparam int unsigned POS_C2_TARGET = 8;
  localparam int unsigned POS_C2_COND = 10;
  localparam int unsigned POS_C2_ACTION = 13;
  localparam int unsigned POS_C3_TARGET = 16;
  localparam int unsigned POS_C3_COND = 18;
  localparam int unsigned POS_C3_ACTION = 21;
  localparam int unsigned POS_C4_TARGET = 24;
  localparam int unsigned POS_C4_COND = 26;
  localparam int unsigned POS_C4_ACTION = 30;
  localparam int unsigned POS_C5_TARGET = 0;
  localparam int unsigned POS_C5_COND = 3;
  localparam int unsigned POS_C5_ACTION = 6;
  localparam int unsigned POS_SYNC_SOURCE = 16;
  localparam int unsigned POS_INDEX_RULE = 20;
  localparam int unsigned POS_MATCH_BITS = 8;
  localparam int unsigned POS_PIN3_FUNCTION = 6;

  // ********************************************************************
  // Codes.
  // ********************************************************************
  localparam logic [3:0] COND_EQ_ANY = 4'h1;
  localparam logic [3:0] COND_EQ_UP = 4'h2;
  localparam logic [3:0] COND_EQ_DOWN = 4'h3;
  localparam logic [3:0] COND_CMP_ABOVE = 4'h4;
  localparam logic [3:0] COND_CMP_BELOW = 4'h5;
  localparam logic [3:0] COND_SOFT_LIMIT = 4'h6;
  localparam logic [3:0] COND_NEVER = 4'h7;
  localparam logic [3:0] COND_INDEX_ANY = 4'h8;
  localparam logic [3:0] COND_INDEX_UP = 4'h9;
  localparam logic [3:0] COND_INDEX_DOWN = 4'ha;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_STOP_NOW = 2'h1;
  localparam logic [1:0] ACT_STOP_DECEL = 2'h2;
  localparam logic [1:0] ACT_BULK_OVERRIDE = 2'h3;
  localparam logic [2:0] TGT_DEVIATION = 3'h2;
  localparam logic [2:0] TGT_REMAINING = 3'h4;
  localparam logic [2:0] TGT_SPEED = 3'h5;
  localparam logic [1:0] PIN_MATCH_LOW = 2'h2;
  localparam logic [1:0] PIN_MATCH_HIGH = 2'h3;

  // ********************************************************************
  // Reset values.
  // ********************************************************************
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage : axis_comparator_bank_pkg

// [hdl/axis_comparator_bank.sv]
/*
 * Five comparators per axis with condition decode, met actions, match status, event
 * interrupt causes, match level pins, index output and internal sync selection.
 * Assumes counters, direction flags and motion state come from neighbouring blocks on
 * the same clock, and software uses a classic Wishbone master.
 */
`timescale 1ns/1ps

module axis_comparator_bank
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [axis_comparator_bank_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Counter values and direction flags.
  input wire logic [axis_comparator_bank_pkg::CMP_W-1:0] position_counter_one_i,
  input wire logic [axis_comparator_bank_pkg::CMP_W-1:0] counter_two_i,
  input wire logic [15:0] deviation_counter_i,
  input wire logic [axis_comparator_bank_pkg::CMP_W-1:0] counter_four_i,
  input wire logic [axis_comparator_bank_pkg::CMP_W-1:0] remaining_pulse_count_i,
  input wire logic [axis_comparator_bank_pkg::CMP_W-1:0] current_speed_i,
  input wire logic [3:0] count_up_i,
  // Motion state.
  input wire logic moving_pos_i,
  input wire logic moving_neg_i,
  // Motion control results.
  output logic stop_now_o,
  output logic stop_decel_o,
  output logic bulk_override_o,
  output logic positive_soft_limit_o,
  output logic negative_soft_limit_o,
  output logic start_pos_inhibit_o,
  output logic start_neg_inhibit_o,
  // Events and pins.
  output logic event_irq_o,
  output logic index_pulse_out_o,
  output logic sync_o,
  output logic [4:0] match_level_out_o,
  output logic [4:0] match_level_oe_o
);
  import axis_comparator_bank_pkg::*;

  // ********************************************************************
  // State.
  // ********************************************************************
  typedef struct packed {
    logic [31:0] cfg_a;
    logic [31:0] cfg_b;
    logic [4:0] irq_en;
    logic [4:0] irq_cause;
    logic [31:0] pin_fn;
    logic [NUM_CMP-1:0][CMP_W-1:0] cmp;
    logic [4:0] met;
    logic [4:0] pin;
    logic [4:0] pin_oe;
    logic idx;
    logic stop_now;
    logic stop_decel;
    logic bulk;
    logic lim_pos;
    logic lim_neg;
    logic sync;
    logic irq;
    logic ack;
    logic [31:0] rdat;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Byte-lane merge of a Wishbone write into a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Target selection; the deviation counter is compared as a magnitude only.
  function automatic logic [CMP_W-1:0] pick(input logic [2:0] tsel,
                                            input logic [CMP_W-1:0] c1,
                                            input logic [CMP_W-1:0] c2,
                                            input logic [15:0] c3,
                                            input logic [CMP_W-1:0] c4,
                                            input logic [CMP_W-1:0] rem,
                                            input logic [CMP_W-1:0] spd);
    logic [15:0] mag;
    logic [CMP_W-1:0] r;
    mag = c3[15] ? 16'(-c3) : c3;
    mag = mag[15] ? 16'h7fff : mag;           // Most negative value saturates.
    case (tsel)
      3'h0: r = c1;
      3'h1: r = c2;
      TGT_DEVIATION: r = {{(CMP_W-16){1'b0}}, mag};
      3'h3: r = c4;
      TGT_REMAINING: r = rem;
      TGT_SPEED: r = spd;
      default: r = '0;
    endcase
    return r;
  endfunction : pick

  // ********************************************************************
  // Next-state logic.
  // ********************************************************************
  logic [4:0][3:0] cond;
  logic [4:0][2:0] tsel;
  logic [4:0][1:0] act;
  logic [4:0] met;
  logic [4:0] imm;
  logic [4:0] dec;
  logic [4:0] blk;
  logic [4:0] rise;
  logic [4:0] up;
  logic [4:0] sl;
  logic idx;
  logic req;
  logic wr;
  logic [CMP_W-1:0] tgt;
  logic signed [CMP_W-1:0] tv;
  logic signed [CMP_W-1:0] cv;
  logic eq;
  logic [3:0] sync_source_select;
  logic [1:0] pf;
  logic [2:0] ci;

  // Field extraction, one comparator at a time.
  always_comb
  begin
    cond[0] = {1'b0, s_q.cfg_a[POS_C1_COND +: 3]};
    cond[1] = {1'b0, s_q.cfg_a[POS_C2_COND +: 3]};
    cond[2] = {1'b0, s_q.cfg_a[POS_C3_COND +: 3]};
    cond[3] = s_q.cfg_a[POS_C4_COND +: 4];    // Only comparator 4 has four bits.
    cond[4] = {1'b0, s_q.cfg_b[POS_C5_COND +: 3]};
    tsel[0] = {1'b0, s_q.cfg_a[POS_C1_TARGET +: 2]};
    tsel[1] = {1'b0, s_q.cfg_a[POS_C2_TARGET +: 2]};
    tsel[2] = {1'b0, s_q.cfg_a[POS_C3_TARGET +: 2]};
    tsel[3] = {1'b0, s_q.cfg_a[POS_C4_TARGET +: 2]};
    tsel[4] = s_q.cfg_b[POS_C5_TARGET +: 3];
    act[0] = s_q.cfg_a[POS_C1_ACTION +: 2];
    act[1] = s_q.cfg_a[POS_C2_ACTION +: 2];
    act[2] = s_q.cfg_a[POS_C3_ACTION +: 2];
    act[3] = s_q.cfg_a[POS_C4_ACTION +: 2];
    act[4] = s_q.cfg_b[POS_C5_ACTION +: 2];
  end

  // Condition evaluation on the live target values, every cycle.
  always_comb
  begin
    met = '0;
    sl = '0;
    up = '0;
    idx = 1'b0;
    tgt = '0;
    tv = '0;
    cv = '0;
    eq = 1'b0;
    ci = '0;
    for (int i = 0; i < NUM_CMP; i++)
    begin
      tgt = pick(tsel[i], position_counter_one_i, counter_two_i, deviation_counter_i,
                 counter_four_i, remaining_pulse_count_i, current_speed_i);
      tv = signed'(tgt);
      cv = signed'(s_q.cmp[i]);
      eq = (cv == tv);
      // Remaining count and speed carry no direction; they follow counter 1.
      ci = (tsel[i] > 3'h3) ? 3'h0 : tsel[i];
      up[i] = count_up_i[ci[1:0]];
      case (cond[i])
        COND_EQ_ANY: met[i] = eq;
        COND_EQ_UP: met[i] = eq && up[i];
        COND_EQ_DOWN: met[i] = eq && !up[i];
        COND_CMP_ABOVE: met[i] = cv > tv;
        COND_CMP_BELOW: met[i] = cv < tv;
        COND_SOFT_LIMIT:
        begin
          // Only comparators 1 and 2 have a limit; elsewhere it stays unmet.
          sl[i] = (i < 2);
          met[i] = (i == 0) ? (cv < tv) : ((i == 1) && (cv > tv));
        end
        COND_INDEX_ANY, COND_INDEX_UP, COND_INDEX_DOWN:
        begin
          // Index rule 0 fires on equality, rule 1 once the selected target reaches the value.
          if (i == 3)
          begin
            met[i] = (s_q.cfg_b[POS_INDEX_RULE] ? (tv >= cv) : eq)
                     && ((cond[i] == COND_INDEX_ANY) || (up[i] == (cond[i] == COND_INDEX_UP)));
            idx = met[i];
          end
        end
        default: met[i] = 1'b0;                // Codes 000, 0111 and spares.
      endcase
    end
  end

  // Met actions; soft limits act only against motion toward them.
  always_comb
  begin
    imm = '0;
    dec = '0;
    blk = '0;
    for (int i = 0; i < NUM_CMP; i++)
    begin
      if (sl[i])
      begin
        // A limit only stops motion heading into it.
        if (met[i] && ((i == 0) ? moving_pos_i : moving_neg_i))
        begin
          dec[i] = (act[i] == ACT_STOP_DECEL); // Comes to rest past the limit.
          imm[i] = (act[i] != ACT_STOP_DECEL);
        end
      end
      else if (met[i])
      begin
        case (act[i])
          ACT_STOP_NOW: imm[i] = 1'b1;
          ACT_STOP_DECEL: dec[i] = 1'b1;
          ACT_BULK_OVERRIDE: blk[i] = 1'b1;
          default: imm[i] = 1'b0;              // No action; status still flows.
        endcase
      end
    end
  end

  assign rise = met & ~s_q.met;
  assign req = cyc_i && stb_i && !s_q.ack;
  assign wr = req && we_i;
  assign sync_source_select = s_q.cfg_b[POS_SYNC_SOURCE +: 4];

  // Register file, pins and status.
  always_comb
  begin
    s_d = s_q;
    pf = '0;
    s_d.met = met;
    s_d.idx = idx;
    s_d.stop_now = |imm;
    s_d.stop_decel = |dec;
    s_d.bulk = |blk;
    s_d.lim_pos = met[0] && sl[0];
    s_d.lim_neg = met[1] && sl[1];
    // Match pins: each uses its own two-bit function field.
    for (int i = 0; i < NUM_CMP; i++)
    begin
      pf = s_q.pin_fn[POS_PIN3_FUNCTION + 2*i +: 2];
      s_d.pin_oe[i] = (pf == PIN_MATCH_LOW) || (pf == PIN_MATCH_HIGH);
      s_d.pin[i] = (pf == PIN_MATCH_LOW) ? !met[i] : (pf == PIN_MATCH_HIGH) && met[i];
    end
    // Sync source follows the selected comparator's rise; spare codes stay quiet.
    s_d.sync = ((sync_source_select >= 4'h1) && (sync_source_select <= 4'h5)) ? rise[3'(sync_source_select - 4'h1)] : 1'b0;
    // Bus answer: one-cycle ack, then a forced idle cycle.
    s_d.ack = req;
    s_d.rdat = '0;
    if (req && !we_i)
    begin
      if (adr_i == OFS_CONFIG_A)
      begin
        s_d.rdat = s_q.cfg_a;
      end
      else if (adr_i == OFS_CONFIG_B)
      begin
        s_d.rdat = s_q.cfg_b;
      end
      else if (adr_i == OFS_IRQ_ENABLE)
      begin
        s_d.rdat[POS_MATCH_BITS +: 5] = s_q.irq_en;
      end
      else if (adr_i == OFS_IRQ_CAUSE)
      begin
        s_d.rdat[POS_MATCH_BITS +: 5] = s_q.irq_cause;
      end
      else if (adr_i == OFS_MAIN_STATUS)
      begin
        s_d.rdat[POS_MATCH_BITS +: 5] = s_q.met;
      end
      else if (adr_i == OFS_PIN_FUNCTION)
      begin
        s_d.rdat = s_q.pin_fn;
      end
      else if ((adr_i >= OFS_COMPARE_BASE) && (adr_i <= OFS_COMPARE_LAST) && (adr_i[1:0] == 2'h0))
      begin
        s_d.rdat[CMP_W-1:0] = s_q.cmp[3'((adr_i - OFS_COMPARE_BASE) >> 2)];
      end
    end
    // Writes; unmapped and read-only words swallow the data but still ack.
    if (wr)
    begin
      if (adr_i == OFS_CONFIG_A)
      begin
        s_d.cfg_a = merge(s_q.cfg_a, dat_i, sel_i);
      end
      else if (adr_i == OFS_CONFIG_B)
      begin
        s_d.cfg_b = merge(s_q.cfg_b, dat_i, sel_i);
      end
      else if ((adr_i == OFS_IRQ_ENABLE) && sel_i[1])
      begin
        s_d.irq_en = dat_i[POS_MATCH_BITS +: 5];
      end
      else if ((adr_i == OFS_IRQ_CAUSE) && sel_i[1])
      begin
        s_d.irq_cause = s_q.irq_cause & ~dat_i[POS_MATCH_BITS +: 5];
      end
      else if (adr_i == OFS_PIN_FUNCTION)
      begin
        s_d.pin_fn = merge(s_q.pin_fn, dat_i, sel_i);
      end
      else if ((adr_i >= OFS_COMPARE_BASE) && (adr_i <= OFS_COMPARE_LAST) && (adr_i[1:0] == 2'h0))
      begin
        s_d.cmp[3'((adr_i - OFS_COMPARE_BASE) >> 2)] =
          CMP_W'(merge({4'h0, s_q.cmp[3'((adr_i - OFS_COMPARE_BASE) >> 2)]}, dat_i, sel_i));
      end
    end
    // A rise in the same cycle as a clear still leaves the cause set.
    s_d.irq_cause = s_d.irq_cause | rise;
    s_d.irq = |(s_d.irq_cause & s_q.irq_en);
  end

  // ********************************************************************
  // State register.
  // ********************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs, all from flip-flops.
  assign dat_o = s_q.rdat;
  assign ack_o = s_q.ack;
  assign stop_now_o = s_q.stop_now;
  assign stop_decel_o = s_q.stop_decel;
  assign bulk_override_o = s_q.bulk;
  assign positive_soft_limit_o = s_q.lim_pos;
  assign negative_soft_limit_o = s_q.lim_neg;
  assign start_pos_inhibit_o = s_q.lim_pos;
  assign start_neg_inhibit_o = s_q.lim_neg;
  assign event_irq_o = s_q.irq;
  assign index_pulse_out_o = s_q.idx;
  assign sync_o = s_q.sync;
  assign match_level_out_o = s_q.pin;
  assign match_level_oe_o = s_q.pin_oe;

endmodule : axis_comparator_bank

// [test/axis_comparator_bank_monitor.sv]
/*
 * Port-level checks for the comparator bank: bus answer timing, limit stops,
 * start inhibits and the sync pulse.
 * Assumes it is bound to the bank's top module and sees its ports by name.
 */
`timescale 1ns/1ps
module axis_comparator_bank_monitor (
  // Clock, reset and bus.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  // Motion and results.
  input wire logic moving_pos_i,
  input wire logic moving_neg_i,
  input wire logic stop_now_o,
  input wire logic stop_decel_o,
  input wire logic positive_soft_limit_o,
  input wire logic negative_soft_limit_o,
  input wire logic start_pos_inhibit_o,
  input wire logic start_neg_inhibit_o,
  input wire logic sync_o
);
  // ********************************************************************
  // Shared clocking and bus sequences.
  // ********************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ans;
    ack_o ##1 !ack_o;
  endsequence

  // ********************************************************************
  // Assertions.
  // ********************************************************************
  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("Request not answered by a single ack.");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("Ack without a request.");
  a_read_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("Read data outside ack cycle.");
  a_pos_inhibit: assert property (start_pos_inhibit_o == positive_soft_limit_o)
    else $error("Positive start inhibit differs from limit.");
  a_neg_inhibit: assert property (start_neg_inhibit_o == negative_soft_limit_o)
    else $error("Negative start inhibit differs from limit.");
  a_pos_stop: assert property ((positive_soft_limit_o && $past(moving_pos_i))
    |-> (stop_now_o || stop_decel_o))
    else $error("Positive limit met while moving but no stop.");
  a_neg_stop: assert property ((negative_soft_limit_o && $past(moving_neg_i))
    |-> (stop_now_o || stop_decel_o))
    else $error("Negative limit met while moving but no stop.");
  a_sync_single: assert property (sync_o |=> !sync_o)
    else $error("Sync pulse longer than one cycle.");
endmodule : axis_comparator_bank_monitor

// [test/tb_axis_comparator_bank.sv]
/*
 * Self-checking bench for the comparator bank, driving bus and counters directly.
 * Assumes the package, the design and the monitor are compiled before it.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_axis_comparator_bank;
  import axis_comparator_bank_pkg::*;
  // ********************************************************************
  // Signals.
  // ********************************************************************
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, moving_pos_i, moving_neg_i;
  logic [7:0] adr_i;
  logic [3:0] sel_i, count_up_i;
  logic [31:0] dat_i, dat_o, q;
  logic [27:0] position_counter_one_i, counter_two_i, counter_four_i;
  logic [27:0] remaining_pulse_count_i, current_speed_i;
  logic [15:0] deviation_counter_i;
  logic stop_now_o, stop_decel_o, bulk_override_o, event_irq_o, index_pulse_out_o, sync_o;
  logic positive_soft_limit_o, negative_soft_limit_o, start_pos_inhibit_o, start_neg_inhibit_o;
  logic [4:0] match_level_out_o, match_level_oe_o;
  int fail_count, n_tests;

  axis_comparator_bank DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .position_counter_one_i, .counter_two_i, .deviation_counter_i,
    .counter_four_i, .remaining_pulse_count_i, .current_speed_i, .count_up_i, .moving_pos_i,
    .moving_neg_i, .stop_now_o, .stop_decel_o, .bulk_override_o, .positive_soft_limit_o,
    .negative_soft_limit_o, .start_pos_inhibit_o, .start_neg_inhibit_o, .event_irq_o,
    .index_pulse_out_o, .sync_o, .match_level_out_o, .match_level_oe_o);

  // 50 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ********************************************************************
  // Helpers.
  // ********************************************************************
  task automatic wrap_up;
    $display("Checks %0d, errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // One classic cycle; the request is held until ack is seen at an edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (n >= 20)
    begin
      fail_count++;
      $display("ERROR bus ack expected 1 seen 0");
      wrap_up();
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask : rd

  // Two edges let the registered outputs follow the inputs.
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic drv(input logic [27:0] v, input logic [3:0] u, input logic p, input logic m);
    @(posedge clk_i);
    position_counter_one_i <= v;
    count_up_i <= u;
    moving_pos_i <= p;
    moving_neg_i <= m;
    settle();
  endtask : drv

  // Comparator one against value 100 with target t.
  function automatic logic exp1(int c, int t, logic u);
    case (c)
      1: return t == 100;
      2: return t == 100 && u;
      3: return t == 100 && !u;
      4: return 100 > t;
      5, 6: return 100 < t;
      default: return 1'b0;
    endcase
  endfunction : exp1

  // ********************************************************************
  // Scenarios.
  // ********************************************************************
  task automatic t_regs;
    rd(OFS_CONFIG_A);
    `CHK("config reset", RST_WORD, q)
    rd(OFS_MAIN_STATUS);
    `CHK("status reset", 32'h0, q)
    wr(OFS_MAIN_STATUS, 32'hffff_ffff);
    rd(OFS_MAIN_STATUS);
    `CHK("status read only", 32'h0, q)
    wr(OFS_COMPARE_BASE, 32'hffff_ffff);
    rd(OFS_COMPARE_BASE);
    `CHK("value width", 32'h0fff_ffff, q)
    rd(8'h40);
    `CHK("unmapped", 32'h0, q)
  endtask : t_regs

  // Every three-bit code, target below, equal and above, both directions.
  task automatic t_cond;
    int t;
    wr(OFS_COMPARE_BASE, 32'd100);
    for (int c = 0; c < 8; c++)
      for (int k = 0; k < 6; k++)
      begin
        t = 50 + 50 * (k / 2);
        wr(OFS_CONFIG_A, 32'(c) << POS_C1_COND);
        drv(28'(t), 4'(k % 2), 1'b0, 1'b0);
        rd(OFS_MAIN_STATUS);
        `CHK("comp1 met", exp1(c, t, k % 2), q[POS_MATCH_BITS])
      end
  endtask : t_cond

  task automatic t_irq;
    int n;
    wr(OFS_CONFIG_A, 32'h4);
    wr(OFS_CONFIG_B, 32'h1 << POS_SYNC_SOURCE);
    wr(OFS_IRQ_ENABLE, 32'h100);
    drv(28'd0, 4'h1, 1'b0, 1'b0);
    wr(OFS_IRQ_CAUSE, 32'h1f00);
    settle();
    `CHK("irq idle", 1'b0, event_irq_o)
    n = 0;
    @(posedge clk_i);
    position_counter_one_i <= 28'd100;
    repeat (4)
    begin
      @(posedge clk_i);
      #1;
      n += sync_o;
    end
    `CHK("sync pulses", 1, n)
    `CHK("irq raised", 1'b1, event_irq_o)
    `CHK("no action stop", 1'b0, stop_now_o)
    rd(OFS_IRQ_CAUSE);
    `CHK("cause set", 1'b1, q[8])
    wr(OFS_IRQ_CAUSE, 32'h100);
    settle();
    `CHK("irq cleared", 1'b0, event_irq_o)
    wr(OFS_IRQ_ENABLE, 32'h0);
    drv(28'd0, 4'h1, 1'b0, 1'b0);
    drv(28'd100, 4'h1, 1'b0, 1'b0);
    `CHK("irq masked", 1'b0, event_irq_o)
    rd(OFS_IRQ_CAUSE);
    `CHK("cause masked", 1'b1, q[8])
    wr(OFS_PIN_FUNCTION, 32'h80);
    settle();
    `CHK("pin low", 2'b10, {match_level_oe_o[0], match_level_out_o[0]})
    wr(OFS_PIN_FUNCTION, 32'hc0);
    settle();
    `CHK("pin high", 2'b11, {match_level_oe_o[0], match_level_out_o[0]})
    drv(28'd0, 4'h1, 1'b0, 1'b0);
    `CHK("pin unmet", 2'b10, {match_level_oe_o[0], match_level_out_o[0]})
    for (int a = 1; a < 4; a++)
    begin
      wr(OFS_CONFIG_A, (32'(a) << POS_C1_ACTION) | 32'h4);
      drv(28'd100, 4'h1, 1'b0, 1'b0);
      `CHK("action", 3'b100 >> (a - 1), {stop_now_o, stop_decel_o, bulk_override_o})
    end
  endtask : t_irq

  task automatic t_limits;
    wr(OFS_COMPARE_BASE, 32'd100);
    wr(OFS_COMPARE_BASE + 8'h4, 32'd10);
    wr(OFS_CONFIG_A, 32'h1818); // Shared target 00, comparator 3 kept off 110.
    drv(28'd150, 4'h1, 1'b1, 1'b0);
    `CHK("pos limit", 5'b11010, {positive_soft_limit_o, stop_now_o, stop_decel_o,
      start_pos_inhibit_o, negative_soft_limit_o})
    wr(OFS_CONFIG_A, 32'h1878);
    settle();
    `CHK("limit bulk", 1'b1, stop_now_o)
    wr(OFS_CONFIG_A, 32'h1858);
    settle();
    `CHK("limit decel", 2'b01, {stop_now_o, stop_decel_o})
    wr(OFS_CONFIG_A, 32'h1818);
    drv(28'd5, 4'h0, 1'b0, 1'b1);
    `CHK("neg limit", 4'b1110, {negative_soft_limit_o, stop_now_o, start_neg_inhibit_o,
      positive_soft_limit_o})
    drv(28'd5, 4'h0, 1'b1, 1'b0);
    `CHK("away from limit", 2'b01, {stop_now_o, start_neg_inhibit_o})
    drv(28'd0, 4'h0, 1'b0, 1'b0);
  endtask : t_limits

  task automatic t_comp4;
    logic [3:0] cs[6] = '{4'h1, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
    logic [1:0] ex[6] = '{2'b10, 2'b00, 2'b11, 2'b11, 2'b00, 2'b00};
    wr(OFS_CONFIG_B, 32'h0);
    wr(OFS_COMPARE_BASE + 8'hc, 32'd100);
    @(posedge clk_i);
    counter_four_i <= 28'd100;
    count_up_i <= 4'h8;
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_CONFIG_A, (32'(cs[i]) << POS_C4_COND) | 32'h0300_0000); // Counter 4 target.
      settle();
      rd(OFS_MAIN_STATUS);
      `CHK("comp4", ex[i], {q[11], index_pulse_out_o})
    end
    // Rule 1 fires once counter 4 has passed a smaller positive value; rule 0 does not.
    wr(OFS_COMPARE_BASE + 8'hc, 32'd50); // Positive value for rule 1.
    wr(OFS_CONFIG_B, 32'h1 << POS_INDEX_RULE);
    wr(OFS_CONFIG_A, (32'(COND_INDEX_UP) << POS_C4_COND) | 32'h0300_0000);
    settle();
    `CHK("index rule one", 1'b1, index_pulse_out_o)
    wr(OFS_CONFIG_B, 32'h0);
    settle();
    `CHK("index rule zero", 1'b0, index_pulse_out_o)
    wr(OFS_CONFIG_A, 32'h0);
  endtask : t_comp4

  task automatic t_comp5;
    wr(OFS_COMPARE_LAST, 32'd5);
    wr(OFS_CONFIG_B, 32'ha);
    @(posedge clk_i);
    deviation_counter_i <= 16'hfffb;
    remaining_pulse_count_i <= 28'd5;
    current_speed_i <= 28'd0;
    settle();
    rd(OFS_MAIN_STATUS);
    `CHK("deviation", 1'b1, q[12])
    wr(OFS_CONFIG_B, 32'hc);
    rd(OFS_MAIN_STATUS);
    `CHK("remaining", 1'b1, q[12])
    wr(OFS_CONFIG_B, 32'hd);
    rd(OFS_MAIN_STATUS);
    `CHK("speed", 1'b0, q[12])
  endtask : t_comp5

  // ********************************************************************
  // Main sequence.
  // ********************************************************************
  initial
  begin
    {cyc_i, stb_i, we_i, moving_pos_i, moving_neg_i} = '0;
    adr_i = '0;
    sel_i = '0;
    dat_i = '0;
    count_up_i = '0;
    {position_counter_one_i, counter_two_i, counter_four_i} = '0;
    {remaining_pulse_count_i, current_speed_i, deviation_counter_i} = '0;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_cond();
    t_irq();
    t_limits();
    t_comp4();
    t_comp5();
    wrap_up();
  end
endmodule : tb_axis_comparator_bank

bind axis_comparator_bank axis_comparator_bank_monitor u_mon (.clk_i, .rst_i, .cyc_i, .stb_i,
  .ack_o, .dat_o, .moving_pos_i, .moving_neg_i, .stop_now_o, .stop_decel_o,
  .positive_soft_limit_o, .negative_soft_limit_o, .start_pos_inhibit_o, .start_neg_inhibit_o,
  .sync_o);
